// file: rtl/iesx_exec.sv
// Purpose: Execution slice for byte/bit set, skip tests, subtract, nibble
//          exchange, table read and exclusive-or of an 8-bit core.
// Assumes: MEM_RDATA holds the addressed byte in the cycle an op is offered;
//          ROM_DATA is valid the cycle after ROM_REQ.
// Notes:   A taken skip costs one dummy cycle in which EXEC_READY is low.
//
// What this block does
// - Byte set writes all ones to the addressed memory byte.
// - Bit set forces only the selected bit to one.
// - Increment memory, write back, skip when the sum is zero.
// - Increment into working register, memory untouched, skip on zero.
// - Taken skip discards prefetched instruction with a dummy cycle.
// - Skip when the selected memory bit is one; memory unchanged.
// - Working minus memory as W plus complement plus one into W.
// - Same subtract, result written back into memory.
// - Working minus immediate as W plus complement plus one into W.
// - Exchange nibbles of the memory byte in place.
// - Exchanged nibbles go to working register, memory unchanged.
// - Skip when the whole memory byte is zero; memory unchanged.
// - Copy memory byte to working register, skip when it is zero.
// - Skip when the selected memory bit is zero.
// - Table read from current page: low byte to memory, high byte held.
// - Table read from last page: low byte to memory, high byte held.
// - Exclusive-or of working register and memory into working register.
// - Exclusive-or of working register and memory into memory.
// - Exclusive-or of working register and immediate into working.
// - Every exclusive-or form updates the zero flag from its result.
`timescale 1ns/1ns
module iesx_exec
	import iesx_pkg::*;
(
	input  wire logic                SYS_CLK,
	input  wire logic                RST,
	input  wire logic                EXEC_VALID,
	input  wire logic [4:0]          EXEC_OP,
	input  wire logic [BITSEL_W-1:0] EXEC_BIT,
	input  wire logic [DATA_W-1:0]   EXEC_IMM,
	input  wire logic [DATA_W-1:0]   MEM_RDATA,
	input  wire logic [PAGE_W-1:0]   PC_PAGE,
	input  wire logic [DATA_W-1:0]   TABLE_POINTER,
	input  wire logic [ROM_W-1:0]    ROM_DATA,
	input  wire logic                ACC_LOAD,
	input  wire logic [DATA_W-1:0]   ACC_DIN,
	output logic                     EXEC_READY,
	output logic                     MEM_WE,
	output logic      [DATA_W-1:0]   MEM_WDATA,
	output logic      [DATA_W-1:0]   ACC,
	output logic                     ZERO_FLAG,
	output logic                     SKIP_NEXT,
	output logic                     ROM_REQ,
	output logic      [ROM_AW-1:0]   ROM_ADDR,
	output logic      [DATA_W-1:0]   TABLE_HIGH_BYTE
);

	// ************************************************************
	// Declarations
	// ************************************************************

	iesx_state_t       state;
	iesx_state_t       next_state;
	iesx_op_t          op;
	logic              take;
	logic              op_legal;

	logic [DATA_W-1:0] add_a;
	logic [DATA_W-1:0] add_b;
	logic [DATA_W-1:0] add_sum;
	logic              add_zero;

	logic [DATA_W-1:0] bit_set_val;
	logic              bit_val;
	logic [DATA_W-1:0] swapped;
	logic [DATA_W-1:0] xor_mem;
	logic [DATA_W-1:0] xor_imm;

	logic              next_mem_we;
	logic [DATA_W-1:0] next_mem_wdata;
	logic              next_acc_we;
	logic [DATA_W-1:0] next_acc;
	logic              next_zero_we;
	logic              next_zero;
	logic              next_skip;
	logic              next_tbl;
	logic [PAGE_W-1:0] next_page;

	// ************************************************************
	// Operand paths
	// ************************************************************

	assign op         = iesx_op_t'(EXEC_OP);
	assign EXEC_READY = (state == ST_IDLE);
	assign take       = EXEC_VALID && EXEC_READY && op_legal;

	iesx_bitop u_bitop (
		.data    (MEM_RDATA),
		.sel     (EXEC_BIT),
		.set_val (bit_set_val),
		.bit_val (bit_val)
	);

	// The adder serves both increments and all subtracts.
	always_comb begin
		add_a = MEM_RDATA;
		add_b = NULL_BYTE;
		unique case (op)
			OP_MINUS_ACC, OP_MINUS_STORE: begin
				add_a = ACC;
				add_b = ~MEM_RDATA;
			end
			OP_MINUS_IMM: begin
				add_a = ACC;
				add_b = ~EXEC_IMM;
			end
			default: begin
				add_a = MEM_RDATA;
				add_b = NULL_BYTE;
			end
		endcase
	end

	iesx_adder u_adder (
		.a       (add_a),
		.b       (add_b),
		.cin     (1'b1),
		.sum     (add_sum),
		.is_zero (add_zero)
	);

	assign swapped = {MEM_RDATA[NIB_LO_MSB:0], MEM_RDATA[NIB_HI_MSB:NIB_HI_LSB]};
	assign xor_mem = ACC ^ MEM_RDATA;
	assign xor_imm = ACC ^ EXEC_IMM;

	// ************************************************************
	// Operation decode
	// ************************************************************

	always_comb begin
		op_legal       = 1'b1;
		next_mem_we    = 1'b0;
		next_mem_wdata = MEM_RDATA;
		next_acc_we    = 1'b0;
		next_acc       = ACC;
		next_zero_we   = 1'b0;
		next_zero      = ZERO_FLAG;
		next_skip      = 1'b0;
		next_tbl       = 1'b0;
		next_page      = PC_PAGE;
		unique case (op)
			OP_SET_BYTE: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = ALL_ONES;
			end
			OP_SET_BIT: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = bit_set_val;
			end
			OP_INC_SKIP: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = add_sum;
				next_skip      = add_zero;
			end
			OP_INC_ACC_SKIP: begin
				next_acc_we = 1'b1;
				next_acc    = add_sum;
				next_skip   = add_zero;
			end
			OP_BIT_ONE_SKIP: begin
				next_skip = bit_val;
			end
			OP_MINUS_ACC: begin
				next_acc_we = 1'b1;
				next_acc    = add_sum;
			end
			OP_MINUS_STORE: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = add_sum;
			end
			OP_MINUS_IMM: begin
				next_acc_we = 1'b1;
				next_acc    = add_sum;
			end
			OP_NIBBLE_XCHG: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = swapped;
			end
			OP_NIBBLE_ACC: begin
				next_acc_we = 1'b1;
				next_acc    = swapped;
			end
			OP_NULL_SKIP: begin
				next_skip = (MEM_RDATA == NULL_BYTE);
			end
			OP_LOAD_SKIP: begin
				next_acc_we = 1'b1;
				next_acc    = MEM_RDATA;
				next_skip   = (MEM_RDATA == NULL_BYTE);
			end
			OP_BIT_ZERO_SKIP: begin
				next_skip = !bit_val;
			end
			OP_TBL_CUR_PAGE: begin
				next_tbl  = 1'b1;
				next_page = PC_PAGE;
			end
			OP_TBL_LAST_PAGE: begin
				next_tbl  = 1'b1;
				next_page = LAST_PAGE;
			end
			OP_XOR_ACC: begin
				next_acc_we  = 1'b1;
				next_acc     = xor_mem;
				next_zero_we = 1'b1;
				next_zero    = (xor_mem == NULL_BYTE);
			end
			OP_XOR_STORE: begin
				next_mem_we    = 1'b1;
				next_mem_wdata = xor_mem;
				next_zero_we   = 1'b1;
				next_zero      = (xor_mem == NULL_BYTE);
			end
			OP_XOR_IMM: begin
				next_acc_we  = 1'b1;
				next_acc     = xor_imm;
				next_zero_we = 1'b1;
				next_zero    = (xor_imm == NULL_BYTE);
			end
			default: begin
				op_legal = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Sequencer
	// ************************************************************

	// A taken skip spends one dummy cycle; a table read waits for ROM.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (take && next_tbl) begin
					next_state = ST_ROM_REQ;
				end else if (take && next_skip) begin
					next_state = ST_DUMMY;
				end
			end
			ST_ROM_REQ: begin
				next_state = ST_ROM_WAIT;
			end
			ST_ROM_WAIT: begin
				next_state = ST_IDLE;
			end
			ST_DUMMY: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// The prefetched instruction is flagged for discard in the dummy cycle.
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			SKIP_NEXT <= 1'b0;
		end else begin
			SKIP_NEXT <= take && next_skip;
		end
	end

	// ************************************************************
	// Program ROM access
	// ************************************************************

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ROM_REQ <= 1'b0;
		end else begin
			ROM_REQ <= take && next_tbl;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ROM_ADDR <= '0;
		end else if (take && next_tbl) begin
			ROM_ADDR <= {next_page, TABLE_POINTER};
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			TABLE_HIGH_BYTE <= TBL_HI_RESET;
		end else if (state == ST_ROM_WAIT) begin
			TABLE_HIGH_BYTE <= ROM_DATA[ROM_W-1:DATA_W];
		end
	end

	// ************************************************************
	// Data memory write port
	// ************************************************************

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MEM_WE <= 1'b0;
		end else begin
			MEM_WE <= (take && next_mem_we) || (state == ST_ROM_WAIT);
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MEM_WDATA <= NULL_BYTE;
		end else if (state == ST_ROM_WAIT) begin
			MEM_WDATA <= ROM_DATA[DATA_W-1:0];
		end else if (take && next_mem_we) begin
			MEM_WDATA <= next_mem_wdata;
		end
	end

	// ************************************************************
	// Working register and zero flag
	// ************************************************************

	// An executed op has priority over a load from the rest of the core.
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ACC <= ACC_RESET;
		end else if (take && next_acc_we) begin
			ACC <= next_acc;
		end else if (ACC_LOAD) begin
			ACC <= ACC_DIN;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ZERO_FLAG <= ZERO_RESET;
		end else if (take && next_zero_we) begin
			ZERO_FLAG <= next_zero;
		end
	end

endmodule

// file: rtl/iesx_pkg.sv
// Purpose: Shared constants and types for the instruction execution slice.
// Assumes: One core clock; program ROM of 3K words in 256-word pages.
// Notes:   Opcode values are local to this slice and decoded upstream.
package iesx_pkg;

	localparam int unsigned DATA_W  = 8;
	localparam int unsigned ROM_W   = 16;
	localparam int unsigned ROM_AW  = 12;
	localparam int unsigned PAGE_W  = 4;
	localparam int unsigned BITSEL_W = 3;

	localparam logic [7:0]        ALL_ONES      = 8'hFF;
	localparam logic [7:0]        NULL_BYTE     = 8'h00;
	localparam logic [PAGE_W-1:0] LAST_PAGE     = 4'hB;
	localparam logic [7:0]        ACC_RESET     = 8'h00;
	localparam logic [7:0]        TBL_HI_RESET  = 8'h00;
	localparam logic              ZERO_RESET    = 1'b0;

	// Nibble field positions.
	localparam int unsigned NIB_LO_MSB = 3;
	localparam int unsigned NIB_HI_LSB = 4;
	localparam int unsigned NIB_HI_MSB = 7;

	typedef enum logic [4:0] {
		OP_SET_BYTE      = 5'h00,
		OP_SET_BIT       = 5'h01,
		OP_INC_SKIP      = 5'h02,
		OP_INC_ACC_SKIP  = 5'h03,
		OP_BIT_ONE_SKIP  = 5'h04,
		OP_MINUS_ACC     = 5'h05,
		OP_MINUS_STORE   = 5'h06,
		OP_MINUS_IMM     = 5'h07,
		OP_NIBBLE_XCHG   = 5'h08,
		OP_NIBBLE_ACC    = 5'h09,
		OP_NULL_SKIP     = 5'h0A,
		OP_LOAD_SKIP     = 5'h0B,
		OP_BIT_ZERO_SKIP = 5'h0C,
		OP_TBL_CUR_PAGE  = 5'h0D,
		OP_TBL_LAST_PAGE = 5'h0E,
		OP_XOR_ACC       = 5'h0F,
		OP_XOR_STORE     = 5'h10,
		OP_XOR_IMM       = 5'h11
	} iesx_op_t;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'h0,
		ST_ROM_REQ  = 2'h1,
		ST_ROM_WAIT = 2'h3,
		ST_DUMMY    = 2'h2
	} iesx_state_t;

endpackage

// file: rtl/iesx_bitop.sv
// Purpose: Bit position decode for bit set and bit test operations.
// Assumes: Select field covers bit positions zero through seven.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module iesx_bitop
	import iesx_pkg::*;
(
	input  wire logic [DATA_W-1:0]   data,
	input  wire logic [BITSEL_W-1:0] sel,
	output logic      [DATA_W-1:0]   set_val,
	output logic                     bit_val
);

	logic [DATA_W-1:0] mask;

	always_comb begin
		mask      = '0;
		mask[sel] = 1'b1;
	end

	assign set_val = data | mask;
	assign bit_val = data[sel];

endmodule

// file: rtl/iesx_adder.sv
// Purpose: Eight-bit adder with carry in and zero detect.
// Assumes: Operands are prepared by the caller (complement, constant).
// Notes:   Carry out is not needed by this slice and is dropped on purpose.
`timescale 1ns/1ns
module iesx_adder
	import iesx_pkg::*;
(
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire logic              cin,
	output logic      [DATA_W-1:0] sum,
	output logic                   is_zero
);

	logic [DATA_W:0] full;

	assign full    = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
	assign sum     = full[DATA_W-1:0];
	assign is_zero = (sum == NULL_BYTE);

endmodule

// file: tb/iesx_exec_props.sv
// Purpose: Concurrent checks on the ports of the execution slice.
// Assumes: One clock; asynchronous active high reset.
// Notes:   Bound into every instance of the execution slice.
`timescale 1ns/1ns
module iesx_exec_props
	import iesx_pkg::*;
(
	input wire logic                SYS_CLK,
	input wire logic                RST,
	input wire logic                EXEC_VALID,
	input wire logic [4:0]          EXEC_OP,
	input wire logic [BITSEL_W-1:0] EXEC_BIT,
	input wire logic [DATA_W-1:0]   EXEC_IMM,
	input wire logic [DATA_W-1:0]   MEM_RDATA,
	input wire logic [PAGE_W-1:0]   PC_PAGE,
	input wire logic [DATA_W-1:0]   TABLE_POINTER,
	input wire logic [ROM_W-1:0]    ROM_DATA,
	input wire logic                ACC_LOAD,
	input wire logic [DATA_W-1:0]   ACC_DIN,
	input wire logic                EXEC_READY,
	input wire logic                MEM_WE,
	input wire logic [DATA_W-1:0]   MEM_WDATA,
	input wire logic [DATA_W-1:0]   ACC,
	input wire logic                ZERO_FLAG,
	input wire logic                SKIP_NEXT,
	input wire logic                ROM_REQ,
	input wire logic [ROM_AW-1:0]   ROM_ADDR,
	input wire logic [DATA_W-1:0]   TABLE_HIGH_BYTE
);
	// ****************************************
	// Port checks
	// ****************************************
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	logic tk;
	assign tk = EXEC_VALID && EXEC_READY;
	set_byte_a: assert property (tk && EXEC_OP == OP_SET_BYTE |=> MEM_WE && MEM_WDATA == ALL_ONES)
		else $error("byte set wrong");
	set_bit_a: assert property (tk && EXEC_OP == OP_SET_BIT |=> MEM_WE &&
		MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << $past(EXEC_BIT)))) else $error("bit set wrong");
	inc_skip_a: assert property (tk && EXEC_OP == OP_INC_SKIP |=> MEM_WE &&
		MEM_WDATA == $past(MEM_RDATA) + 8'h01 && SKIP_NEXT == (MEM_WDATA == NULL_BYTE)) else $error("inc skip wrong");
	null_skip_a: assert property (tk && EXEC_OP == OP_NULL_SKIP |=>
		!MEM_WE && SKIP_NEXT == ($past(MEM_RDATA) == NULL_BYTE)) else $error("null skip wrong");
	dummy_gap_a: assert property (SKIP_NEXT |-> !EXEC_READY ##1 (EXEC_READY && !SKIP_NEXT))
		else $error("dummy cycle wrong");
	minus_acc_a: assert property (tk && EXEC_OP == OP_MINUS_ACC |=>
		ACC == $past(ACC) + ~$past(MEM_RDATA) + 8'h01) else $error("subtract wrong");
	xor_zero_a: assert property (tk && EXEC_OP == OP_XOR_IMM |=> ACC == ($past(ACC) ^ $past(EXEC_IMM)) &&
		ZERO_FLAG == (ACC == NULL_BYTE)) else $error("xor flag wrong");
	tbl_addr_a: assert property (tk && EXEC_OP == OP_TBL_LAST_PAGE |=>
		ROM_REQ && ROM_ADDR == {LAST_PAGE, $past(TABLE_POINTER)}) else $error("table address wrong");
	tbl_data_a: assert property (ROM_REQ |=> !EXEC_READY ##1 MEM_WE && MEM_WDATA == $past(ROM_DATA[7:0]) &&
		TABLE_HIGH_BYTE == $past(ROM_DATA[15:8])) else $error("table data wrong");
	skip_seen_c: cover property (SKIP_NEXT ##1 EXEC_READY);
	tbl_seen_c: cover property (ROM_REQ ##2 MEM_WE);
	xor_null_c: cover property (tk && EXEC_OP == OP_XOR_ACC ##1 ZERO_FLAG);
endmodule
bind iesx_exec iesx_exec_props iesx_exec_props_i (.*);

// file: tb/test_instruction_exec_slice.sv
// Purpose: Self-checking bench for the execution slice.
// Assumes: Each op starts when the slice is idle and stays offered while it is busy; ROM answers one cycle late.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ns
module test_instruction_exec_slice
	import iesx_pkg::*;
;
	logic        clk, rst, vld, ld, we, sk, rdy, rreq, zf, m_z;
	logic [4:0]  op;
	logic [2:0]  bsel;
	logic [3:0]  page;
	logic [7:0]  imm, mem, ptr, din, wd, acc, thb, m_acc;
	logic [11:0] raddr;
	logic [15:0] rom;
	logic [31:0] seed = 32'h0000C568;
	int          miscompares, compares, cyc;

	iesx_exec iesx_exec_i (.SYS_CLK(clk), .RST(rst), .EXEC_VALID(vld), .EXEC_OP(op), .EXEC_BIT(bsel),
		.EXEC_IMM(imm), .MEM_RDATA(mem), .PC_PAGE(page), .TABLE_POINTER(ptr), .ROM_DATA(rom), .ACC_LOAD(ld),
		.ACC_DIN(din), .EXEC_READY(rdy), .MEM_WE(we), .MEM_WDATA(wd), .ACC(acc), .ZERO_FLAG(zf),
		.SKIP_NEXT(sk), .ROM_REQ(rreq), .ROM_ADDR(raddr), .TABLE_HIGH_BYTE(thb));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Offers one op; the held offer during a dummy or table cycle must be ignored.
	task automatic run_op(input logic [4:0] o, input logic [7:0] m);
		logic [7:0]  w;
		logic [15:0] r;
		logic        ew, es, et, wa;
		logic [31:0] x;
		x = rnd();
		r = x[31:16];
		{ew, es, et, wa, w} = 12'h000;
		case (o)
			OP_SET_BYTE:      {ew, w} = {1'b1, ALL_ONES};
			OP_SET_BIT:       {ew, w} = {1'b1, m | (8'h01 << x[2:0])};
			OP_INC_SKIP:      {ew, w} = {1'b1, m + 8'h01};
			OP_INC_ACC_SKIP:  {wa, w} = {1'b1, m + 8'h01};
			OP_BIT_ONE_SKIP:  es = m[x[2:0]];
			OP_MINUS_ACC:     {wa, w} = {1'b1, m_acc + ~m + 8'h01};
			OP_MINUS_STORE:   {ew, w} = {1'b1, m_acc + ~m + 8'h01};
			OP_MINUS_IMM:     {wa, w} = {1'b1, m_acc + ~x[15:8] + 8'h01};
			OP_NIBBLE_XCHG:   {ew, w} = {1'b1, m[3:0], m[7:4]};
			OP_NIBBLE_ACC:    {wa, w} = {1'b1, m[3:0], m[7:4]};
			OP_NULL_SKIP:     es = (m == 8'h00);
			OP_LOAD_SKIP:     {wa, w} = {1'b1, m};
			OP_BIT_ZERO_SKIP: es = !m[x[2:0]];
			OP_TBL_CUR_PAGE:  et = 1'b1;
			OP_TBL_LAST_PAGE: et = 1'b1;
			OP_XOR_ACC:       {wa, w} = {1'b1, m_acc ^ m};
			OP_XOR_STORE:     {ew, w} = {1'b1, m_acc ^ m};
			OP_XOR_IMM:       {wa, w} = {1'b1, m_acc ^ x[15:8]};
			default:          w = 8'h00;
		endcase
		if (o inside {OP_INC_SKIP, OP_INC_ACC_SKIP, OP_LOAD_SKIP}) es = (w == 8'h00);
		if (o inside {OP_XOR_ACC, OP_XOR_STORE, OP_XOR_IMM}) m_z = (w == 8'h00);
		{vld, ld, op, mem, bsel, imm, page, ptr, din} = {1'b1, x[3], o, m, x[2:0], x[15:8], x[7:4],
			x[23:16], x[31:24]};
		if (wa) m_acc = w;
		else if (x[3]) m_acc = din;
		@(posedge clk);
		#1;
		chk("mem_we", 16'(ew), 16'(we));
		if (ew) chk("mem_wdata", 16'(w), 16'(wd));
		chk("acc", 16'(m_acc), 16'(acc));
		chk("zero_flag", 16'(m_z), 16'(zf));
		chk("skip", 16'(es), 16'(sk));
		chk("ready", 16'(!(es | et)), 16'(rdy));
		if (es) begin
			@(posedge clk);
			#1;
			chk("dummy_end", 16'h0001, {14'h0, sk, rdy});
			// A load held through the dummy cycle lands after the op's own write.
			if (ld) m_acc = din;
			chk("dummy_acc", 16'(m_acc), 16'(acc));
		end
		if (et) begin
			chk("rom_req", 16'h0001, 16'(rreq));
			chk("rom_addr", {4'h0, (o == OP_TBL_LAST_PAGE) ? LAST_PAGE : page, ptr}, 16'(raddr));
			rom = r;
			repeat (2) @(posedge clk);
			#1;
			chk("tbl_word", r, {thb, wd});
			chk("tbl_we_ready", 16'h0003, {14'h0, we, rdy});
			rom = ~r;
		end
	endtask

	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		{rst, vld, ld, op, bsel, imm, mem, page, ptr, rom, din, m_acc, m_z} = {1'b1, 71'h0};
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset_regs", 16'h0000, {acc, thb});
		chk("reset_flags", 16'h0001, {11'h0, zf, sk, we, rreq, rdy});
		chk("reset_addr", 16'h0000, 16'(raddr));
		for (int i = 0; i < 20; i++) begin
			run_op(5'(i), 8'hFF);
			run_op(5'(i), 8'h00);
			run_op(5'(i), m_acc);
		end
		for (int i = 0; i < 400; i++) begin
			run_op(5'(rnd() % 20), 8'(rnd()));
		end
		end_of_test();
	end
endmodule
